// ===== verification/ttd_peer_unit.sv
// Peer unit model: 576 kc sync pulse source for the timing lock input
`timescale 1ns/100ps
module ttd_peer_unit (
    input  wire logic        mclk_i,   // Shared system clock
    input  wire logic        run_i,    // High while the peer sends sync
    input  wire logic [11:0] period_i, // Sync spacing in clocks
    output logic             sync_o    // Sync pulse train
);
    logic [11:0] cnt; // Clocks since the last pulse began

    initial begin
        sync_o = 1'b0;
        cnt    = 12'h000;
    end

    // ****************************************************************
    // Pulse generator
    // ****************************************************************
    // Short pulse each period; a stopped peer leaves the line low,
    // so the block must rely on its own loss detection to recover
    always @(posedge mclk_i) begin
        if (!run_i) begin
            cnt    <= #1 12'h000;
            sync_o <= #1 1'b0;
        end else begin
            cnt    <= #1 (cnt >= period_i - 12'h001) ? 12'h000
                                                     : cnt + 12'h001;
            sync_o <= #1 (cnt < 12'h008);
        end
    end
endmodule

// ===== verification/ttd_transmit_timing_tb_top.sv
// Testbench for the transmit timing divider against a peer sync source
`timescale 1ns/100ps
module ttd_transmit_timing_tb_top;
    import ttd_pkg::*;
    localparam int DLY  = 25;    // Pulse clock lag in clocks
    localparam int LOSS = 625;   // Silence before reverting to master
    localparam int CEIL = 40000; // Timeout in clocks
    logic        mclk_i;         // System clock
    logic        rst_i;          // Synchronous reset
    logic        sync_in_i;      // Timing lock input from peer
    logic        peer_run;       // Peer sync enable
    logic [11:0] peer_period;    // Peer sync spacing
    ttd_timing_s timing_o;       // Divider outputs
    logic        sync_out_xmt_o; // Transmit timing output
    logic        slave_mode_o;   // Slave indication
    logic        h, hn, pc, q, qn, t3, t3n, f, hp, tp; // Output aliases
    logic [DLY-1:0] hist;        // Past half rate levels
    int n_fail, samples_checked, cycles, since_sync, since_rst;
    int n_half, n_hfall, n_q, n_t3, n_t3rise, n_f; // Edge counters

    assign {h, hn, pc, q, qn, t3, t3n, f} = timing_o;

    ttd_transmit_timing #(.DLY_DEPTH(DLY), .LOSS_LIMIT(LOSS))
    i_ttd_transmit_timing (
        .mclk_i         (mclk_i),
        .rst_i          (rst_i),
        .sync_in_i      (sync_in_i),
        .timing_o       (timing_o),
        .sync_out_xmt_o (sync_out_xmt_o),
        .slave_mode_o   (slave_mode_o)
    );

    ttd_peer_unit i_ttd_peer_unit (
        .mclk_i   (mclk_i),
        .run_i    (peer_run),
        .period_i (peer_period),
        .sync_o   (sync_in_i)
    );

    // ****************************************************************
    // Helpers
    // ****************************************************************
    task automatic chk(input logic ok, input string msg);
        samples_checked++;
        if (ok !== 1'b1) begin
            n_fail++;
            $display("[ERR] %0t %s", $time, msg);
        end
    endtask

    function automatic logic near(input int a, input int b, input int t);
        return (a - b <= t) && (b - a <= t);
    endfunction

    // Waits for the n-th clock after a sync edge, bounded
    task automatic wait_since(input int n);
        int k;
        k = 0;
        do begin
            @(posedge mclk_i);
            #1;
            k++;
        end while (since_sync != n && k < 2000);
        chk(k < 2000, "sync wait ran out");
    endtask

    task automatic close_out;
        $display("Checks: %0d  mismatches: %0d", samples_checked, n_fail);
        if (n_fail == 0 && samples_checked > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask

    // ****************************************************************
    // Clock and continuous monitor
    // ****************************************************************
    initial mclk_i = 1'b0;
    always #4 mclk_i = ~mclk_i;

    // Edge counting and lag check on levels settled before the edge
    always @(posedge mclk_i) begin
        cycles++;
        since_sync = (sync_in_i === 1'b1 && hist[0] !== 1'bx && !tp)
                   ? 0 : since_sync + 1;
        tp = sync_in_i;
        since_rst = rst_i ? 0 : since_rst + 1;
        if (since_rst > DLY + 2) begin
            chk(hn === ~h && qn === ~q && t3n === ~t3, "complement");
            chk(pc === hist[DLY-1], "pulse clock lag");
            n_half   += int'(h != hp);
            n_hfall  += int'(hp && !h);
        end
        hist = {hist[DLY-2:0], h};
        hp = h;
        if (cycles >= CEIL) begin
            n_fail++;
            $display("[ERR] %0t run too long", $time);
            close_out();
        end
    end

    // Stage edge counts, kept apart from the lag logic above
    logic qp, t3p, fp; // Previous stage levels
    always @(posedge mclk_i) begin
        if (since_rst > 2) begin
            n_q      += int'(q != qp);
            n_t3     += int'(t3 != t3p);
            n_t3rise += int'(t3 && !t3p);
            n_f      += int'(f != fp);
        end
        {qp, t3p, fp} = {q, t3, f};
    end

    // ****************************************************************
    // Scenarios
    // ****************************************************************
    task automatic t_reset;
        repeat (3) @(posedge mclk_i);
        #1 rst_i = 1'b0;
        @(posedge mclk_i);
        #1;
        chk(timing_o === TIMING_RST, "timing reset value");
        chk({sync_out_xmt_o, slave_mode_o} === 2'b00, "mode reset");
    endtask

    // Free run: rates and stage relations with no sync present
    task automatic t_master;
        int h0, f0, q0, t0, r0, g0;
        {h0, f0, q0, t0, r0, g0} = {n_half, n_hfall, n_q, n_t3,
                                    n_t3rise, n_f};
        repeat (6000) begin
            @(posedge mclk_i);
            #1;
            chk(sync_out_xmt_o === q && slave_mode_o === 1'b0, "sync out");
        end
        chk(near(n_half - h0, 111, 2), "base tick rate");
        chk(near(n_q - q0, n_hfall - f0, 1), "second stage");
        chk(near(3 * (n_t3 - t0), n_half - h0, 4), "third stage");
        chk(near(n_f - g0, n_t3rise - r0, 1), "final stage");
        chk(near(6 * (n_f - g0), n_half - h0, 7), "divide by six");
    endtask

    // Locked run at a given sync spacing
    task automatic t_slave(input logic [11:0] per);
        int h0, zeros;
        peer_period = per;
        peer_run = 1'b1;
        wait_since(1);
        chk(slave_mode_o === 1'b1, "slave entry");
        @(posedge mclk_i);
        #1;
        chk(sync_out_xmt_o === 1'b0, "self timing off");
        wait_since(1);
        wait_since(1);
        h0 = n_half;
        zeros = 0;
        repeat (8 * int'(per)) begin
            @(posedge mclk_i);
            #1;
            chk(slave_mode_o === 1'b1 && sync_out_xmt_o === 1'b0, "hold");
            if (since_sync == DLY + 1) begin
                chk(q === 1'b0, "second stage reset");
                zeros += int'(h === 1'b0);
            end
        end
        chk(near(n_half - h0, 32, 1), "four ticks per sync");
        chk(zeros >= 4, "first stage reset");
    endtask

    // Sync stops: slave holds, then reverts to self timing
    task automatic t_loss;
        peer_run = 1'b0;
        wait_since(LOSS - 2);
        chk(slave_mode_o === 1'b1, "slave held in silence");
        wait_since(LOSS + 3);
        chk(slave_mode_o === 1'b0, "reverted to master");
        repeat (300) begin
            @(posedge mclk_i);
            #1;
            chk(sync_out_xmt_o === q, "sync out resumed");
        end
    endtask

    initial begin
        rst_i = 1'b1;
        peer_run = 1'b0;
        peer_period = 12'h0D9;
        {n_fail, samples_checked, cycles, since_sync, since_rst} = '0;
        {n_half, n_hfall, n_q, n_t3, n_t3rise, n_f} = '0;
        tp = 1'b0;
        t_reset();
        t_master();
        t_slave(12'h0D9);
        t_slave(12'h0F0);
        t_loss();
        close_out();
    end
endmodule

// ===== verilog/ttd_pkg.sv
// Constants and carrier types for the transmit timing divider
package ttd_pkg;

    // ****************************************************************
    // Clock and timing figures
    // ****************************************************************
    localparam int unsigned CLK_KHZ       = 125000;  // System clock rate
    localparam int unsigned CLK_PS        = 8000;    // System clock period
    localparam int unsigned BASE_KHZ      = 2304;    // Base frequency
    localparam int unsigned SYNC_PER_BASE = 4;       // Base ticks per sync
    localparam int unsigned DLY_PS        = 200000;  // 0.2 us lag
    localparam int unsigned LOSS_PS       = 5000000; // 5 us of silence

    // Cycle counts derived from the times above (least times round up)
    localparam int unsigned DLY_CYC  = (DLY_PS + CLK_PS - 1) / CLK_PS;
    localparam int unsigned LOSS_CYC = (LOSS_PS + CLK_PS - 1) / CLK_PS;

    // ****************************************************************
    // Oscillator accumulator
    // ****************************************************************
    localparam int unsigned NCO_W   = 24;            // Accumulator width
    localparam longint      NCO_ONE = 64'h1000000;   // Two to the NCO_W
    localparam logic [NCO_W-1:0] NCO_INC =
        NCO_W'((longint'(BASE_KHZ) * NCO_ONE) / longint'(CLK_KHZ));

    // ****************************************************************
    // Counter widths and reset values
    // ****************************************************************
    localparam int unsigned PER_W   = 12;            // Sync period counter
    localparam int unsigned LOSS_W  = 12;            // Silence counter
    localparam logic [1:0]  DIV3_LAST = 2'h2;        // Last count of /3
    localparam logic [1:0]  DIV3_RST  = 2'h0;        // Reset of /3

    // Mode of the frequency reference
    typedef enum logic {
        TTD_MASTER,
        TTD_SLAVE
    } ttd_mode_e;

    // All divider outputs, carried together
    typedef struct packed {
        logic half_rate_square_wave;      // 1,152 kc true
        logic half_rate_square_wave_n;    // 1,152 kc complement
        logic pulse_clock;                // 1,152 kc lagged 0.2 us
        logic quarter_rate_square_wave;   // 576 kc true
        logic quarter_rate_square_wave_n; // 576 kc complement
        logic third_stage_output;         // 384 kc true
        logic third_stage_output_n;       // 384 kc complement
        logic final_stage_output;         // 192 kc
    } ttd_timing_s;

    localparam ttd_timing_s TIMING_RST = '{
        half_rate_square_wave_n    : 1'b1,
        quarter_rate_square_wave_n : 1'b1,
        third_stage_output_n       : 1'b1,
        default                    : 1'b0
    };

endpackage

// ===== verilog/ttd_transmit_timing.sv
// Transmit timing divider: reference select, countdown chain, sync lock
`timescale 1ns/100ps
// How it works
// - Master runs from its own free oscillator
// - Master drives 576 kc on transmit timing
// - Received sync disables self generation
// - Slave base locks to four times sync
// - Suppression held while sync pulses continue
// - Drop-and-insert: both units run as slaves
// - First stage toggles, true and complement
// - Pulse clock lags first stage 0.2 us
// - Second stage follows first stage true output
// - Second stage gives 576 kc, both forms
// - Third stage follows base tick, every third
// - Chain reduces 1,152 kc to 192 kc
// - Divide by six: two halves, one 1.5
// - AND gate feeds back later stages
// - Final stage clocked by AND output
// - Sync resets stage one alternately, two always
// - Sync resets delayed by 0.2 us
module ttd_transmit_timing #(
    parameter int unsigned DLY_DEPTH  = ttd_pkg::DLY_CYC,  // Lag cycles
    parameter int unsigned LOSS_LIMIT = ttd_pkg::LOSS_CYC  // Loss cycles
) (
    input  wire logic                 mclk_i,            // 125 MHz clock
    input  wire logic                 rst_i,             // Sync reset
    input  wire logic                 sync_in_i,         // Timing lock in
    output ttd_pkg::ttd_timing_s      timing_o,          // Divider outputs
    output logic                      sync_out_xmt_o,    // 576 kc to slave
    output logic                      slave_mode_o       // High when slaved
);
    import ttd_pkg::*;

    // ****************************************************************
    // State
    // ****************************************************************
    logic                 sync_d_reg,   sync_d_next;    // Sync edge memory
    ttd_mode_e            mode_reg,     mode_next;      // Reference mode
    logic [LOSS_W-1:0]    loss_reg,     loss_next;      // Silence count
    logic [PER_W-1:0]     per_cnt_reg,  per_cnt_next;   // Running period
    logic [PER_W-1:0]     period_reg,   period_next;    // Last sync period
    logic [PER_W-1:0]     sub_reg,      sub_next;       // Slave tick timer
    logic [1:0]           nt_reg,       nt_next;        // Ticks since sync
    logic [NCO_W-1:0]     acc_reg,      acc_next;       // Master oscillator
    logic                 tick_reg,     tick_next;      // Base clock enable
    logic [DLY_DEPTH-1:0] sdly_reg,     sdly_next;      // Sync lag line
    logic [DLY_DEPTH-1:0] pdly_reg,     pdly_next;      // Pulse clock line
    logic                 alt_reg,      alt_next;       // Every other sync
    logic [1:0]           div3_reg,     div3_next;      // 1.5 stage phase
    ttd_timing_s          tim_reg,      tim_next;       // Output stages
    logic                 xmt_reg,      xmt_next;       // Transmit timing

    logic sync_rise;       // One cycle per incoming sync pulse
    logic sync_late;       // Sync pulse after the 0.2 us lag
    logic fb_and;          // Feedback gate firing the third stage
    logic s1_fall;         // First stage true output falling
    logic s2_fall;         // Second stage true output falling

    // ****************************************************************
    // Reference selection and base tick
    // ****************************************************************

    // Mode detect, period measure and base tick generation
    always_comb begin
        sync_d_next  = sync_in_i;
        sync_rise    = sync_in_i & ~sync_d_reg;
        mode_next    = mode_reg;
        loss_next    = loss_reg;
        per_cnt_next = per_cnt_reg + PER_W'(1);
        period_next  = period_reg;
        sub_next     = sub_reg + PER_W'(1);
        nt_next      = nt_reg;
        acc_next     = acc_reg;
        tick_next    = 1'b0;
        if (sync_rise) begin
            mode_next    = TTD_SLAVE;
            loss_next    = '0;
            per_cnt_next = PER_W'(1);
            period_next  = per_cnt_reg;
            nt_next      = '0;
        end else if (loss_reg == LOSS_W'(LOSS_LIMIT)) begin
            mode_next = TTD_MASTER;
        end else begin
            loss_next = loss_reg + LOSS_W'(1);
        end
        if (mode_reg == TTD_MASTER) begin
            // Accumulator carry marks one base period
            {tick_next, acc_next} = {1'b0, acc_reg} + {1'b0, NCO_INC};
        end else if (sync_rise) begin
            // Each sync restarts the quarter period timer
            sub_next  = PER_W'(1);
            tick_next = 1'b1;
        end else if (sub_reg >= (period_reg >> 2)
                     && nt_reg != 2'(SYNC_PER_BASE - 1)) begin
            // Three fill-in ticks; the sync edge gives the fourth, so a
            // period not divisible by four cannot squeeze in a fifth
            sub_next  = PER_W'(1);
            nt_next   = nt_reg + 2'h1;
            tick_next = 1'b1;
        end
    end

    // Registering of the reference state
    always_ff @(posedge mclk_i) begin
        if (rst_i) begin
            sync_d_reg  <= 1'b0;
            mode_reg    <= TTD_MASTER;
            loss_reg    <= '0;
            per_cnt_reg <= '0;
            period_reg  <= '0;
            sub_reg     <= '0;
            nt_reg      <= '0;
            acc_reg     <= '0;
            tick_reg    <= 1'b0;
        end else begin
            sync_d_reg  <= sync_d_next;
            mode_reg    <= mode_next;
            loss_reg    <= loss_next;
            per_cnt_reg <= per_cnt_next;
            period_reg  <= period_next;
            sub_reg     <= sub_next;
            nt_reg      <= nt_next;
            acc_reg     <= acc_next;
            tick_reg    <= tick_next;
        end
    end

    // ****************************************************************
    // Countdown chain
    // ****************************************************************

    // Every stage steps on the base tick, no ripple clocks
    always_comb begin
        sdly_next = {sdly_reg[DLY_DEPTH-2:0], sync_rise};
        sync_late = sdly_reg[DLY_DEPTH-1] & (mode_reg == TTD_SLAVE);
        alt_next  = alt_reg;
        div3_next = div3_reg;
        tim_next  = tim_reg;
        s1_fall   = 1'b0;
        s2_fall   = 1'b0;
        // Gate of the 1.5 stage: it fires on the last /3 phase
        fb_and    = tick_reg & div3_reg[1] & ~div3_reg[0];
        if (tick_reg) begin
            tim_next.half_rate_square_wave =
                ~tim_reg.half_rate_square_wave;
            s1_fall = tim_reg.half_rate_square_wave;
            div3_next = (div3_reg == DIV3_LAST) ? DIV3_RST
                                                : div3_reg + 2'h1;
        end
        if (s1_fall) begin
            tim_next.quarter_rate_square_wave =
                ~tim_reg.quarter_rate_square_wave;
            s2_fall = tim_reg.quarter_rate_square_wave;
        end
        if (fb_and) begin
            // Third stage steps every third base tick
            tim_next.third_stage_output = ~tim_reg.third_stage_output;
            if (!tim_reg.third_stage_output) begin
                tim_next.final_stage_output =
                    ~tim_reg.final_stage_output;
            end
        end
        if (sync_late) begin
            // Realign to sync once countdown has settled
            alt_next = ~alt_reg;
            tim_next.quarter_rate_square_wave = 1'b0;
            if (alt_reg) begin
                tim_next.half_rate_square_wave = 1'b0;
            end
        end
        // Complements always mirror the true outputs
        tim_next.half_rate_square_wave_n =
            ~tim_next.half_rate_square_wave;
        tim_next.quarter_rate_square_wave_n =
            ~tim_next.quarter_rate_square_wave;
        tim_next.third_stage_output_n = ~tim_next.third_stage_output;
        tim_next.pulse_clock = pdly_reg[DLY_DEPTH-1];
        // Line fed from the next value so the lag equals the depth
        pdly_next = {pdly_reg[DLY_DEPTH-2:0],
                     tim_next.half_rate_square_wave};
        // Only a master hands out its 576 kc
        xmt_next = (mode_reg == TTD_MASTER)
                 & tim_next.quarter_rate_square_wave;
    end

    // Registering of the chain; s2_fall unused beyond monitoring
    always_ff @(posedge mclk_i) begin
        if (rst_i) begin
            sdly_reg <= '0;
            pdly_reg <= '0;
            alt_reg  <= 1'b0;
            div3_reg <= DIV3_RST;
            tim_reg  <= TIMING_RST;
            xmt_reg  <= 1'b0;
        end else begin
            sdly_reg <= sdly_next;
            pdly_reg <= pdly_next;
            alt_reg  <= alt_next;
            div3_reg <= div3_next;
            tim_reg  <= tim_next;
            xmt_reg  <= xmt_next;
        end
    end

    // Outputs straight from flip-flops
    assign timing_o       = tim_reg;
    assign sync_out_xmt_o = xmt_reg;
    assign slave_mode_o   = (mode_reg == TTD_SLAVE);

    // ****************************************************************
    // Assertions
    // ****************************************************************
    logic [5:0] up_reg;    // Cycles since reset, saturating
    always_ff @(posedge mclk_i) begin
        if (rst_i) begin
            up_reg <= '0;
        end else if (up_reg != 6'h3F) begin
            up_reg <= up_reg + 6'h01;
        end
    end

    AST_MASTER_TICK: assert property (@(posedge mclk_i) disable iff (rst_i)
        mode_reg == TTD_MASTER |-> ##[1:60]
            (tick_reg || mode_reg == TTD_SLAVE))
        else $error("master base tick missing");
    AST_TX_MASTER: assert property (@(posedge mclk_i) disable iff (rst_i)
        (mode_reg == TTD_MASTER && $past(mode_reg) == TTD_MASTER
         && up_reg > 6'h2) |->
            sync_out_xmt_o == timing_o.quarter_rate_square_wave)
        else $error("master transmit timing wrong");
    AST_SYNC_SLAVES: assert property (@(posedge mclk_i) disable iff (rst_i)
        sync_rise |=> slave_mode_o ##1 !sync_out_xmt_o)
        else $error("sync did not force slave");
    AST_SLAVE_HOLD: assert property (@(posedge mclk_i) disable iff (rst_i)
        (slave_mode_o && loss_reg < LOSS_W'(LOSS_LIMIT)) |=> slave_mode_o)
        else $error("slave dropped while sync present");
    AST_FIRST_TOGGLE: assert property (@(posedge mclk_i) disable iff (rst_i)
        (tick_reg && !sync_late) |=>
            $changed(timing_o.half_rate_square_wave))
        else $error("first stage did not toggle");
    AST_COMPLEMENT: assert property (@(posedge mclk_i) disable iff (rst_i)
        timing_o.half_rate_square_wave != timing_o.half_rate_square_wave_n
        && timing_o.quarter_rate_square_wave
           != timing_o.quarter_rate_square_wave_n)
        else $error("complement outputs not exact");
    AST_PULSE_LAG: assert property (@(posedge mclk_i) disable iff (rst_i)
        up_reg == 6'h3F |-> timing_o.pulse_clock ==
            $past(timing_o.half_rate_square_wave, 25))
        else $error("pulse clock lag wrong");
    AST_THIRD_RATE: assert property (@(posedge mclk_i) disable iff (rst_i)
        fb_and |=> $changed(timing_o.third_stage_output))
        else $error("third stage missed gate");
    AST_FINAL_STEP: assert property (@(posedge mclk_i) disable iff (rst_i)
        $rose(timing_o.third_stage_output) |->
            $changed(timing_o.final_stage_output))
        else $error("final stage not clocked by gate");
    AST_SYNC_RESET: assert property (@(posedge mclk_i) disable iff (rst_i)
        sync_late |=> !timing_o.quarter_rate_square_wave)
        else $error("sync reset of second stage missed");
    AST_SYNC_LAG: assert property (@(posedge mclk_i) disable iff (rst_i)
        (sync_rise && slave_mode_o) |-> ##25 sync_late)
        else $error("sync reset lag wrong");

    COV_SLAVE_ENTRY: cover property (@(posedge mclk_i) disable iff (rst_i)
        !slave_mode_o ##1 slave_mode_o);
    COV_SYNC_LOSS: cover property (@(posedge mclk_i) disable iff (rst_i)
        slave_mode_o ##1 !slave_mode_o);
    COV_FINAL_RISE: cover property (@(posedge mclk_i) disable iff (rst_i)
        $rose(timing_o.final_stage_output));
    COV_S2_FALL: cover property (@(posedge mclk_i) disable iff (rst_i)
        s2_fall && sync_late);

endmodule
